// ---- core/rcg_pkg.sv ----
// constants and types shared by the reset and clock guard
// assumes the core clock is the high-frequency oscillator clock
package rcg_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	// malfunction stretch, in high_clock_frequency periods (core clock is that clock)
	localparam int STRETCH_HF_PERIODS = 24;
	localparam int STRETCH_CYC = STRETCH_HF_PERIODS;
	localparam int STRETCH_W = 5;
	// external reset pin must stay low this long
	localparam int EXT_MIN_MACHINE_CYC = 3;
	localparam int HF_PER_MACHINE_CYC = 4;
	localparam int EXT_MIN_CYC = EXT_MIN_MACHINE_CYC * HF_PER_MACHINE_CYC;
	localparam int EXT_CNT_W = 4;
	localparam logic [EXT_CNT_W-1:0] EXT_MIN_CNT = EXT_CNT_W'(EXT_MIN_CYC);
	localparam logic [EXT_CNT_W-1:0] EXT_LAST_CNT = EXT_CNT_W'(EXT_MIN_CYC - 1);

	// ----------------------------------------
	// addresses and field positions
	// ----------------------------------------
	localparam logic [15:0] VEC_ADDR_LO = 16'hfffe;
	localparam logic [15:0] VEC_ADDR_HI = 16'hffff;
	localparam int XEN_BIT = 7;
	localparam int XTEN_BIT = 6;
	localparam int SYSCK_BIT = 5;
	localparam int TRAP_LATCH_BIT = 2;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic xen;
		logic xten;
		logic sysck;
	} rcg_sysctl_t;

	typedef struct packed {
		logic trap_action_select;
		logic trap_ram_area_select;
		logic wdt_enable;
	} rcg_wdtctl_t;

	typedef enum logic [1:0] {
		rm_high_freq_run_mode_one,
		rm_high_freq_run_mode_two,
		rm_low_freq_run_mode,
		rm_low_freq_run_mode_two
	} rcg_run_mode_t;

	typedef enum logic [2:0] {
		BT_HOLD,
		BT_VEC_LO,
		BT_VEC_HI,
		BT_LOAD,
		BT_JUMP,
		BT_RUN
	} rcg_boot_t;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam rcg_sysctl_t SYSCTL_RST = '{xen: 1'b1, xten: 1'b0, sysck: 1'b0};
	localparam rcg_wdtctl_t WDTCTL_RST = '{trap_action_select: 1'b1,
		trap_ram_area_select: 1'b0, wdt_enable: 1'b1};

endpackage : rcg_pkg

// ---- core/rcg_stretch.sv ----
// malfunction reset stretch counter
// assumes load comes from logic on the same clock
`timescale 1ns/1ps
module rcg_stretch
	import rcg_pkg::*;
#(
	parameter int CYC = STRETCH_CYC,
	parameter int W = STRETCH_W
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	output logic busy
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [W-1:0] cnt;
	} rcg_stretch_t;

	rcg_stretch_t st_ff;
	rcg_stretch_t nxt_st;

	generate
		if (CYC < 1 || CYC >= (1 << W))
		begin : g_bad
			$error("stretch count does not fit its counter");
		end
	endgenerate

	// reload on every request, count down to zero
	always_comb
	begin
		nxt_st = st_ff;
		if (load)
			nxt_st.cnt = W'(CYC);
		else if (st_ff.cnt != '0)
			nxt_st.cnt = st_ff.cnt - W'(1);
	end

	// no power-on clear: comes up stretching, as the real circuit may
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_ff <= '{cnt: W'(CYC)};
		else
			st_ff <= nxt_st;
	end

	assign busy = (st_ff.cnt != '0);

endmodule : rcg_stretch

// ---- core/rcg_guard.sv ----
// reset generation and low-to-high clock switch guard
// assumes clk is the high-frequency clock; reset pin and low clock arrive asynchronously
`timescale 1ns/1ps

// Overview of operation
// - a low reset pin ends low-frequency run mode and restart is in run mode one.
// - after clock select clears, the low clock stays until a low-clock edge syncs the switch.
// - reset sources are the pin, address trap, watchdog and clock fault; last three malfunction.
// - a malfunction request holds internal reset for 24 high clock periods after the last request.
// - the malfunction stretch is not cleared at power-up, so a 24-period reset may appear.
// - reset clears the master enable, all enable flags and all request latches.
// - reset clears the timing generator and enables the watchdog.
// - on pin release execution starts from the vector held at the two top bytes.
// - fetch from the register area, or from RAM when the RAM select is set, traps.
// - a trap either resets or requests an interrupt, and the trapped area is selectable.
// - after a trap reset the vector is read, then the instruction at it is fetched.
// - dropping both oscillators, the active high one, or the active low one is a fault reset.
module rcg_guard
	import rcg_pkg::*;
#(
	parameter int NUM_IRQ = 16,
	parameter logic [15:0] SPECIAL_LO = 16'h0000,
	parameter logic [15:0] SPECIAL_HI = 16'h003f,
	parameter logic [15:0] RAM_LO = 16'h0040,
	parameter logic [15:0] RAM_HI = 16'h023f
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reset_pin_n,
	input wire logic lf_clk_level,
	input wire logic wdt_rst_req,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic sysctl_wr,
	input wire logic [7:0] sysctl_wdata,
	input wire logic wdtctl_wr,
	input wire rcg_wdtctl_t wdtctl_wdata,
	input wire logic irq_master_wr,
	input wire logic irq_master_wdata,
	input wire logic irq_en_wr,
	input wire logic [NUM_IRQ-1:0] irq_en_wdata,
	input wire logic irq_lat_wr,
	input wire logic [NUM_IRQ-1:0] irq_lat_wdata,
	input wire logic [NUM_IRQ-1:0] irq_set,
	input wire logic [7:0] mem_rd_data,
	output logic cpu_rst,
	output logic tg_clear,
	output rcg_wdtctl_t watchdog_control_one,
	output rcg_sysctl_t system_control_two,
	output rcg_run_mode_t run_mode,
	output logic main_clk_is_low,
	output logic master_irq_enable,
	output logic [NUM_IRQ-1:0] irq_enable_flags,
	output logic [NUM_IRQ-1:0] irq_request_latches,
	output logic mem_rd_req,
	output logic [15:0] mem_rd_addr,
	output logic pc_load,
	output logic [15:0] pc_value
);

	// ----------------------------------------
	// state and helpers
	// ----------------------------------------
	typedef struct packed {
		logic rst_meta;
		logic rst_sync;
		logic [EXT_CNT_W-1:0] ext_cnt;
		logic ext_active;
		logic lf_meta;
		logic lf_sync;
		logic lf_prev;
		rcg_sysctl_t sysctl;
		logic clk_low;
		logic sw_pending;
		rcg_wdtctl_t wdt;
		logic irq_master;
		logic [NUM_IRQ-1:0] irq_en;
		logic [NUM_IRQ-1:0] irq_lat;
		rcg_boot_t boot;
		logic [7:0] vec_lo;
		logic [15:0] pc;
	} rcg_state_t;

	localparam rcg_state_t ST_RST = '{
		rst_meta: 1'b1, rst_sync: 1'b1, ext_cnt: '0, ext_active: 1'b1,
		lf_meta: 1'b0, lf_sync: 1'b0, lf_prev: 1'b0,
		sysctl: SYSCTL_RST, clk_low: 1'b0, sw_pending: 1'b0, wdt: WDTCTL_RST,
		irq_master: 1'b0, irq_en: '0, irq_lat: '0, boot: BT_HOLD, vec_lo: 8'h00, pc: 16'h0000};

	rcg_state_t st_ff;
	rcg_state_t nxt_st;
	rcg_sysctl_t new_ctl;
	logic stretch_busy;
	logic lf_edge;
	logic trap_hit;
	logic sysclk_fault;
	logic malf_req;

	generate
		if (NUM_IRQ <= TRAP_LATCH_BIT || SPECIAL_HI < SPECIAL_LO || RAM_HI < RAM_LO)
		begin : g_bad
			$error("irq count or trap area bounds cannot be served");
		end
	endgenerate

	function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_area = (a >= lo) && (a <= hi);
	endfunction : in_area

	function automatic rcg_run_mode_t mode_of(input rcg_sysctl_t c);
		if (!c.sysck)
			mode_of = c.xten ? rm_high_freq_run_mode_two : rm_high_freq_run_mode_one;
		else
			mode_of = c.xen ? rm_low_freq_run_mode_two : rm_low_freq_run_mode;
	endfunction : mode_of

	// ----------------------------------------
	// request decode
	// ----------------------------------------
	// fetch into a protected area while running
	assign trap_hit = fetch_valid & ~cpu_rst & (in_area(fetch_addr, SPECIAL_LO, SPECIAL_HI) |
		(st_ff.wdt.trap_ram_area_select & in_area(fetch_addr, RAM_LO, RAM_HI)));

	assign new_ctl.xen = sysctl_wdata[XEN_BIT];
	assign new_ctl.xten = sysctl_wdata[XTEN_BIT];
	assign new_ctl.sysck = sysctl_wdata[SYSCK_BIT];

	// a write that would stop the clock the core runs on
	assign sysclk_fault = sysctl_wr & ~cpu_rst & (
		(st_ff.sysctl.xen & st_ff.sysctl.xten & ~new_ctl.xen & ~new_ctl.xten) |
		(st_ff.sysctl.xen & ~new_ctl.xen & ~st_ff.sysctl.sysck) |
		(st_ff.sysctl.xten & ~new_ctl.xten & st_ff.sysctl.sysck));

	// three malfunction sources share one stretch
	assign malf_req = wdt_rst_req | sysclk_fault |
		(trap_hit & st_ff.wdt.trap_action_select);

	assign lf_edge = st_ff.lf_sync & ~st_ff.lf_prev;

	rcg_stretch #(
		.CYC(STRETCH_CYC),
		.W(STRETCH_W)
	) u_stretch (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(malf_req),
		.busy(stretch_busy)
	);

	assign cpu_rst = st_ff.ext_active | stretch_busy;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		// synchronisers: first stage feeds only the second
		nxt_st.rst_meta = reset_pin_n;
		nxt_st.rst_sync = st_ff.rst_meta;
		nxt_st.lf_meta = lf_clk_level;
		nxt_st.lf_sync = st_ff.lf_meta;
		nxt_st.lf_prev = st_ff.lf_sync;
		// short glitches on the pin never reach the core
		if (st_ff.rst_sync)
		begin
			nxt_st.ext_cnt = '0;
			nxt_st.ext_active = 1'b0;
		end
		else
		begin
			if (st_ff.ext_cnt != EXT_MIN_CNT)
				nxt_st.ext_cnt = st_ff.ext_cnt + EXT_CNT_W'(1);
			if (st_ff.ext_cnt == EXT_LAST_CNT)
				nxt_st.ext_active = 1'b1;
		end
		if (cpu_rst)
		begin
			nxt_st.sysctl = SYSCTL_RST;
			nxt_st.clk_low = 1'b0;
			nxt_st.sw_pending = 1'b0;
			nxt_st.wdt = WDTCTL_RST;
			nxt_st.irq_master = 1'b0;
			nxt_st.irq_en = '0;
			nxt_st.irq_lat = '0;
			nxt_st.boot = BT_HOLD;
		end
		else
		begin
			// switch to the high clock only on a low-clock edge
			if (st_ff.sw_pending & lf_edge)
			begin
				nxt_st.clk_low = 1'b0;
				nxt_st.sw_pending = 1'b0;
			end
			// a faulting write is dropped, oscillators keep running
			if (sysctl_wr & ~sysclk_fault)
			begin
				nxt_st.sysctl = new_ctl;
				if (new_ctl.sysck)
				begin
					nxt_st.clk_low = 1'b1;
					nxt_st.sw_pending = 1'b0;
				end
				else if (st_ff.sysctl.sysck)
					nxt_st.sw_pending = 1'b1;
			end
			if (wdtctl_wr)
				nxt_st.wdt = wdtctl_wdata;
			if (irq_master_wr)
				nxt_st.irq_master = irq_master_wdata;
			if (irq_en_wr)
				nxt_st.irq_en = irq_en_wdata;
			// hardware set wins over a software clear in the same cycle
			nxt_st.irq_lat = (irq_lat_wr ? irq_lat_wdata : st_ff.irq_lat) | irq_set;
			if (trap_hit & ~st_ff.wdt.trap_action_select)
				nxt_st.irq_lat[TRAP_LATCH_BIT] = 1'b1;
			// vector fetch sequence after any reset
			case (st_ff.boot)
				BT_HOLD: nxt_st.boot = BT_VEC_LO;
				BT_VEC_LO: nxt_st.boot = BT_VEC_HI;
				BT_VEC_HI:
				begin
					nxt_st.vec_lo = mem_rd_data;
					nxt_st.boot = BT_LOAD;
				end
				BT_LOAD:
				begin
					nxt_st.pc = {mem_rd_data, st_ff.vec_lo};
					nxt_st.boot = BT_JUMP;
				end
				BT_JUMP: nxt_st.boot = BT_RUN;
				BT_RUN: nxt_st.boot = BT_RUN;
				default: nxt_st.boot = BT_HOLD;
			endcase
		end
	end

	// power-up holds the core in reset through the stretch; the pin synchroniser comes up high
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign tg_clear = cpu_rst;
	assign watchdog_control_one = st_ff.wdt;
	assign system_control_two = st_ff.sysctl;
	assign run_mode = mode_of(st_ff.sysctl);
	assign main_clk_is_low = st_ff.clk_low;
	assign master_irq_enable = st_ff.irq_master;
	assign irq_enable_flags = st_ff.irq_en;
	assign irq_request_latches = st_ff.irq_lat;
	// vector read: low byte first, data expected the following cycle
	assign mem_rd_req = (st_ff.boot == BT_VEC_LO) || (st_ff.boot == BT_VEC_HI);
	assign mem_rd_addr = (st_ff.boot == BT_VEC_HI) ? VEC_ADDR_HI : VEC_ADDR_LO;
	assign pc_load = (st_ff.boot == BT_JUMP);
	assign pc_value = st_ff.pc;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	localparam int STRETCH_LIM = STRETCH_CYC;
	logic [7:0] hlp_busy_cnt_ff;

	// cycles of stretch since the last request
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			hlp_busy_cnt_ff <= 8'h00;
		else if (malf_req)
			hlp_busy_cnt_ff <= 8'h00;
		else if (stretch_busy && hlp_busy_cnt_ff != 8'hff)
			hlp_busy_cnt_ff <= hlp_busy_cnt_ff + 8'h01;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence seq_vec_lo;
		mem_rd_req && mem_rd_addr == VEC_ADDR_LO;
	endsequence
	sequence seq_vec_hi;
		mem_rd_req && mem_rd_addr == VEC_ADDR_HI;
	endsequence
	sequence seq_boot;
		seq_vec_lo ##1 seq_vec_hi ##2
			(pc_load && pc_value == {$past(mem_rd_data), $past(mem_rd_data, 2)});
	endsequence

	AST_STRETCH_MAX: assert property (stretch_busy && !malf_req |->
		hlp_busy_cnt_ff < STRETCH_LIM) else $error("stretch longer than allowed");
	AST_STRETCH_HOLD: assert property (malf_req |=> stretch_busy[*8])
		else $error("malfunction request not stretched");
	AST_EXT_APPLY: assert property ($rose(st_ff.ext_active) |->
		$past(st_ff.ext_cnt) == EXT_LAST_CNT && !$past(st_ff.rst_sync))
		else $error("pin reset applied too early");
	AST_EXT_RELEASE: assert property (st_ff.rst_sync && st_ff.ext_active |=>
		!st_ff.ext_active) else $error("pin reset not released");
	AST_RESET_MODE: assert property (cpu_rst |=> run_mode == rm_high_freq_run_mode_one &&
		!main_clk_is_low) else $error("reset did not return to run mode one");
	AST_IRQ_CLEAR: assert property (cpu_rst |=> !master_irq_enable &&
		irq_enable_flags == '0 && irq_request_latches == '0)
		else $error("interrupt state not cleared by reset");
	AST_WDT_ON: assert property (cpu_rst |=> watchdog_control_one.wdt_enable &&
		watchdog_control_one.trap_action_select) else $error("watchdog not enabled by reset");
	AST_BOOT_SEQ: assert property ($fell(cpu_rst) |-> ##1 (seq_boot or ##[0:3] cpu_rst))
		else $error("vector fetch sequence wrong");
	AST_TRAP_RST: assert property (trap_hit && watchdog_control_one.trap_action_select |=>
		cpu_rst) else $error("trap did not reset");
	AST_TRAP_IRQ: assert property (trap_hit && !watchdog_control_one.trap_action_select &&
		!malf_req |=> irq_request_latches[TRAP_LATCH_BIT]) else $error("trap irq not latched");
	AST_SYSCLK_FAULT: assert property (sysclk_fault |=> cpu_rst &&
		$stable(system_control_two)) else $error("clock fault not handled");
	AST_CLK_HOLD: assert property (st_ff.sw_pending && !lf_edge && !cpu_rst &&
		!sysctl_wr |=> main_clk_is_low) else $error("left low clock before sync");
	AST_CLK_SWITCH: assert property (st_ff.sw_pending && lf_edge && !cpu_rst &&
		!sysctl_wr |=> !main_clk_is_low) else $error("clock switch missed sync edge");

endmodule : rcg_guard

// ---- verification/rcg_ext_model.sv ----
// far side of the guard: vector memory, low oscillator and reset pin driver
// assumes the guard samples every input on the rising edge of clk
`timescale 1ns/1ps
module rcg_ext_model
	import rcg_pkg::*;
#(
	parameter logic [15:0] VEC = 16'h5a3c,
	parameter int LF_HALF = 7
)
(
	input wire logic clk,
	input wire logic mem_rd_req,
	input wire logic [15:0] mem_rd_addr,
	input wire logic pin_go,
	output logic [7:0] mem_rd_data,
	output logic reset_pin_n,
	output logic lf_clk_level
);
	// ----------------------------------------
	// model state
	// ----------------------------------------
	int lf_cnt = 0;
	int low_cnt = 0;
	initial
	begin
		mem_rd_data = 8'h00;
		reset_pin_n = 1'b1;
		lf_clk_level = 1'b0;
	end
	// byte answers one cycle later; idle data toggles so a stale byte never matches
	always @(posedge clk)
	begin
		if (mem_rd_req)
			mem_rd_data <= (mem_rd_addr == VEC_ADDR_LO) ? VEC[7:0] : VEC[15:8];
		else
			mem_rd_data <= ~mem_rd_data;
		if (pin_go)
			low_cnt <= EXT_MIN_CYC;
		else if (low_cnt != 0)
			low_cnt <= low_cnt - 1;
	end
	// pin and low clock move off the sampling edge; low oscillator runs free
	always @(negedge clk)
	begin
		reset_pin_n <= (low_cnt == 0);
		lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
		if (lf_cnt == LF_HALF - 1)
			lf_clk_level <= ~lf_clk_level;
	end
endmodule : rcg_ext_model

// ---- verification/reset_and_clock_guard_test.sv ----
// self-checking bench for the reset and clock guard
// assumes rcg_pkg is compiled first; inputs move on the falling edge
`timescale 1ns/1ps
module reset_and_clock_guard_test
	import rcg_pkg::*;
;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam logic [15:0] VEC = 16'h5a3c;
	logic clk = 1'b0, sys_rst = 1'b1, wdt_rst_req = 1'b0, fetch_valid = 1'b0, pin_go = 1'b0;
	logic sysctl_wr = 1'b0, wdtctl_wr = 1'b0, irq_master_wr = 1'b0, irq_master_wdata = 1'b0;
	logic irq_en_wr = 1'b0, irq_lat_wr = 1'b0;
	logic [15:0] fetch_addr = 16'h0000, irq_en_wdata = 16'h0000, irq_lat_wdata = 16'h0000;
	logic [15:0] irq_set = 16'h0000;
	logic [7:0] sysctl_wdata = 8'h00;
	rcg_wdtctl_t wdtctl_wdata = WDTCTL_RST;
	logic cpu_rst, tg_clear, main_clk_is_low, master_irq_enable, mem_rd_req, pc_load;
	logic reset_pin_n, lf_clk_level;
	logic [7:0] mem_rd_data;
	rcg_wdtctl_t watchdog_control_one;
	rcg_sysctl_t system_control_two;
	rcg_run_mode_t run_mode;
	logic [15:0] irq_enable_flags, irq_request_latches, mem_rd_addr, pc_value;
	int n_fail = 0;
	int checked = 0;
	int n;
	logic [2:0] prep [3] = '{3'b110, 3'b111, 3'b111};
	logic [2:0] bad [3] = '{3'b010, 3'b001, 3'b101};

	rcg_guard dut_u (.clk, .sys_rst, .reset_pin_n, .lf_clk_level, .wdt_rst_req, .fetch_valid,
		.fetch_addr, .sysctl_wr, .sysctl_wdata, .wdtctl_wr, .wdtctl_wdata, .irq_master_wr,
		.irq_master_wdata, .irq_en_wr, .irq_en_wdata, .irq_lat_wr, .irq_lat_wdata, .irq_set,
		.mem_rd_data, .cpu_rst, .tg_clear,
		.watchdog_control_one, .system_control_two, .run_mode, .main_clk_is_low,
		.master_irq_enable, .irq_enable_flags, .irq_request_latches, .mem_rd_req,
		.mem_rd_addr, .pc_load, .pc_value);
	rcg_ext_model #(.VEC(VEC)) ext_u (.clk, .mem_rd_req, .mem_rd_addr, .pin_go, .mem_rd_data,
		.reset_pin_n, .lf_clk_level);

	// 200 MHz core clock
	initial
	begin
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// one cycle; strobes drop so every request is a single-cycle pulse
	task automatic step();
		@(negedge clk);
		{wdt_rst_req, fetch_valid, sysctl_wr, wdtctl_wr} = '0;
		{irq_master_wr, irq_en_wr, irq_lat_wr, pin_go} = '0;
		irq_set = 16'h0000;
	endtask : step

	task automatic set_sys(input logic [2:0] v);
		sysctl_wdata = {v, 5'h00};
		sysctl_wr = 1'b1;
	endtask : set_sys

	// counts cycles of internal reset after a request raised by the caller
	task automatic rst_len(output int len);
		len = 0;
		step();
		repeat (100)
		begin
			if (cpu_rst === 1'b1)
				len++;
			else if (len > 0)
				break;
			step();
		end
	endtask : rst_len

	// vector fetch after release; a hang here ends the run
	task automatic boot();
		int i;
		for (i = 0; i < 300 && mem_rd_req !== 1'b1; i++)
			step();
		chk(mem_rd_req, 1'b1);
		chk(mem_rd_addr, VEC_ADDR_LO);
		step();
		chk(mem_rd_addr, VEC_ADDR_HI);
		for (i = 0; i < 4 && pc_load !== 1'b1; i++)
			step();
		chk(pc_value, VEC);
		if (pc_load !== 1'b1)
		begin
			n_fail++;
			complete_run();
		end
		step();
	endtask : boot

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		repeat (12) step();
		chk(tg_clear, 1'b1);
		sys_rst = 1'b0;
		repeat (20) step();
		chk(cpu_rst, 1'b1);
		boot();
		chk(watchdog_control_one, WDTCTL_RST);
		chk(system_control_two, SYSCTL_RST);
		chk(run_mode, rm_high_freq_run_mode_one);
		$display("test power_up done");
		{irq_master_wr, irq_master_wdata, irq_en_wr, irq_lat_wr} = 4'hf;
		irq_en_wdata = 16'hffff;
		irq_lat_wdata = 16'h00f0;
		// a hardware request in the load cycle must survive the load
		irq_set = 16'h0100;
		step();
		chk(irq_request_latches, 16'h01f0);
		chk(master_irq_enable, 1'b1);
		chk(irq_enable_flags, 16'hffff);
		wdt_rst_req = 1'b1;
		rst_len(n);
		chk(n, STRETCH_CYC);
		boot();
		chk(master_irq_enable, 1'b0);
		chk(irq_enable_flags, 16'h0000);
		chk(irq_request_latches, 16'h0000);
		$display("test watchdog done");
		fetch_valid = 1'b1;
		fetch_addr = 16'h003f;
		rst_len(n);
		chk(n, STRETCH_CYC);
		boot();
		fetch_valid = 1'b1;
		fetch_addr = 16'h0040;
		rst_len(n);
		chk(n, 16'h0000);
		wdtctl_wdata = 3'b011;
		wdtctl_wr = 1'b1;
		step();
		fetch_valid = 1'b1;
		fetch_addr = 16'h023f;
		step();
		chk(irq_request_latches[TRAP_LATCH_BIT], 1'b1);
		chk(cpu_rst, 1'b0);
		$display("test trap done");
		for (int k = 0; k < 3; k++)
		begin
			set_sys(prep[k]);
			// strobe stays up for the back-to-back write
			@(negedge clk);
			set_sys(bad[k]);
			rst_len(n);
			chk(n, STRETCH_CYC);
			boot();
		end
		chk(watchdog_control_one, WDTCTL_RST);
		$display("test clock_fault done");
		set_sys(3'b111);
		@(negedge clk);
		set_sys(3'b011);
		step();
		chk(main_clk_is_low, 1'b1);
		chk(run_mode, rm_low_freq_run_mode);
		set_sys(3'b111);
		// warm-up of the high oscillator before leaving the low clock
		repeat (50) step();
		set_sys(3'b110);
		step();
		chk(main_clk_is_low, 1'b1);
		for (int i = 0; i < 40 && main_clk_is_low !== 1'b0; i++)
			step();
		chk(main_clk_is_low, 1'b0);
		set_sys(3'b111);
		@(negedge clk);
		set_sys(3'b011);
		step();
		pin_go = 1'b1;
		rst_len(n);
		chk(n != 0, 1'b1);
		boot();
		chk(run_mode, rm_high_freq_run_mode_one);
		chk(main_clk_is_low, 1'b0);
		$display("test clock_switch done");
		complete_run();
	end
endmodule : reset_and_clock_guard_test
